//--- verilog/exec_defs.svh
/*
 * Offsets, field positions, reset values and windows of the execution block.
 * Assumes inclusion by bare name from the shift unit and the top design module.
 */
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

`define OFF_CMD      8'h00
`define OFF_STATUS   8'h04
`define OFF_ZPTR     8'h08
`define OFF_SP       8'h0C
`define OFF_FLAGS    8'h10
`define OFF_CTRL     8'h14

`define CMD_OP_LSB   0
`define CMD_REG_LSB  5
`define CMD_BIT_LSB  10
`define CMD_IO_LSB   13

`define FLG_C        0
`define FLG_Z        1
`define FLG_N        2
`define FLG_V        3
`define FLG_S        4
`define FLG_H        5
`define FLG_T        6
`define FLG_I        7

`define SP_RST       16'h2FFF
`define FLAGS_RST    8'h00
`define SRAM_LO      16'h2000
`define SRAM_HI      16'h2FFF
`define PM_STEP      16'h0002

`define RESP_OKAY    2'h0
`define RESP_DECERR  2'h3

`endif

//--- verilog/exec_pkg.sv
/*
 * Types of the execution block: operation codes and sequencer states.
 * Assumes the defs header is on the include path.
 */
package exec_pkg;
    typedef enum logic [4:0] {
        op_nop, op_pm_store, op_pm_store_inc, op_port_read, op_port_write,
        op_push, op_pop, op_reg_ram_trade, op_load_or_into_ram,
        op_load_clear_bits_ram, op_load_xor_into_ram, op_shift_left_logical,
        op_shift_right_logical, op_rotate_left_carry, op_rotate_right_carry,
        op_shift_right_arith, op_copy_bit_to_t_flag, op_copy_t_flag_to_bit,
        op_set_io_bit, op_clear_io_bit, op_flag_on, op_flag_off
    } op_e;

    typedef enum logic [2:0] {st_idle, st_wait, st_exec, st_wb, st_pm_wait} state_e;

    function automatic logic is_atomic(input op_e op);
        return op inside {op_reg_ram_trade, op_load_or_into_ram,
                          op_load_clear_bits_ram, op_load_xor_into_ram};
    endfunction

    function automatic logic is_mem_rd(input op_e op);
        return is_atomic(op) || op == op_pop;
    endfunction

    function automatic logic is_shift(input op_e op);
        return op inside {op_shift_left_logical, op_shift_right_logical,
                          op_rotate_left_carry, op_rotate_right_carry, op_shift_right_arith};
    endfunction
endpackage

//--- verilog/shift_unit.sv
/*
 * Shift and rotate datapath with flag update.
 * Assumes the caller uses the outputs only for shift and rotate operations.
 */
`timescale 1ns/1ns
`include "exec_defs.svh"
module shift_unit
    import exec_pkg::*;
(
    input  wire op_e        op,
    input  wire logic [7:0] din,
    input  wire logic [7:0] fin,
    output logic      [7:0] dout,
    output logic      [7:0] fout
);
    logic c;
    logic h;
    logic n;
    logic v;

    always_comb begin
        dout = din;
        c    = fin[`FLG_C];
        h    = fin[`FLG_H];
        case (op)
            op_shift_left_logical: begin
                dout = {din[6:0], 1'b0};
                c    = din[7];
                h    = din[3];
            end
            op_rotate_left_carry: begin
                dout = {din[6:0], fin[`FLG_C]};
                c    = din[7];
                h    = din[3];
            end
            op_shift_right_logical: begin
                dout = {1'b0, din[7:1]};
                c    = din[0];
            end
            op_rotate_right_carry: begin
                dout = {fin[`FLG_C], din[7:1]};
                c    = din[0];
            end
            op_shift_right_arith: begin
                dout = {din[7], din[7:1]};
                c    = din[0];
            end
            default: begin
            end
        endcase
        n             = dout[7];
        v             = n ^ c;
        fout          = fin;
        fout[`FLG_C]  = c;
        fout[`FLG_Z]  = (dout == 8'h00);
        fout[`FLG_N]  = n;
        fout[`FLG_V]  = v;
        fout[`FLG_S]  = n ^ v;
        // Right shifts leave H alone
        fout[`FLG_H]  = h;
    end
endmodule // shift_unit

//--- verilog/rmw_unit.sv
/*
 * Write-back value of the atomic RAM operations.
 * Assumes old register and old RAM byte are both presented in the same cycle.
 */
`timescale 1ns/1ns
module rmw_unit
    import exec_pkg::*;
(
    input  wire op_e        op,
    input  wire logic [7:0] reg_val,
    input  wire logic [7:0] ram_val,
    output logic      [7:0] wr_val
);
    always_comb begin
        case (op)
            op_load_or_into_ram:    wr_val = reg_val | ram_val;
            op_load_clear_bits_ram: wr_val = ~reg_val & ram_val;
            op_load_xor_into_ram:   wr_val = reg_val ^ ram_val;
            default:                wr_val = reg_val;
        endcase
    end
endmodule // rmw_unit

//--- verilog/cpu_instruction_subset_exec.sv
/*
 * Execution unit for a subset of an 8-bit instruction set, issued over AXI4-Lite.
 * Assumes program memory, data SRAM and I/O space on the same clock; data SRAM
 * and I/O answer reads combinationally in the cycle of the request.
 */
// Functional notes
// - Program store writes R1:R0, optional Z plus two
// - Port read and write take one cycle
// - Push one cycle, pop two cycles
// - Exchange swaps register and RAM at Z
// - Load-and-set writes register OR RAM back
// - Load-and-clear writes RAM AND NOT register
// - Load-and-toggle writes register XOR RAM back
// - Rotate left through carry, updates ZCNVH
// - Rotate right through carry, H untouched
// - Arithmetic right shift keeps bit seven
// - Bit to T, T to bit
// - I/O bit set and clear, one cycle
// - Interrupt enable flag set or cleared
// - Overflow flag set or cleared alone
// - Signed flag set or cleared alone
// - Half carry flag set or cleared alone
// - Internal SRAM reads add one cycle
// - External memory reads wait on ready
`timescale 1ns/1ns
`include "exec_defs.svh"
module cpu_instruction_subset_exec
    import exec_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             pm_req,
    output logic [23:0]      pm_addr,
    output logic [15:0]      pm_wdata,
    input  wire logic        pm_done,
    output logic             dm_req,
    output logic             dm_we,
    output logic [15:0]      dm_addr,
    output logic [7:0]       dm_wdata,
    input  wire logic [7:0]  dm_rdata,
    input  wire logic        dm_ready,
    output logic             io_re,
    output logic             io_we,
    output logic [5:0]       io_addr,
    output logic [7:0]       io_wdata,
    output logic [7:0]       io_wmask,
    input  wire logic [7:0]  io_rdata
);
    logic [7:0]  regs [32];
    logic [31:0] cmd_r;
    op_e         op_r;
    logic [4:0]  rd_r;
    logic [2:0]  bit_r;
    logic [15:0] z_r;
    logic [7:0]  zext_r;
    logic [15:0] sp_r;
    logic [7:0]  flags_r;
    logic        wait_en_r;
    state_e      state_r;
    state_e      state_nxt;
    logic [7:0]  tmp_r;
    logic [7:0]  cyc_r;
    logic [7:0]  last_cyc_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic [31:0] wr_old;
    logic [31:0] wr_data;
    logic [31:0] rd_val;
    logic        wr_fire;
    logic        sw_wr;
    logic        accept;
    logic        busy;
    logic        exec_go;
    logic        needs_wait;
    op_e         cmd_op;
    logic [4:0]  cmd_rd;
    logic [2:0]  cmd_bit;
    logic [15:0] mem_addr_n;
    logic [7:0]  sh_dout;
    logic [7:0]  sh_fout;
    logic [7:0]  rmw_val;

    function automatic logic addr_ok(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a[7] || a <= `OFF_CTRL);
    endfunction

    // One view of every register, shared by reads and by strobe merges
    function automatic logic [31:0] reg_view(input logic [7:0] a);
        if (a[7]) begin
            return {24'h0, regs[a[6:2]]};
        end
        case (a)
            `OFF_CMD:    return cmd_r;
            `OFF_STATUS: return {8'h0, last_cyc_r, flags_r, 5'h0, state_r == st_wait,
                                 state_r == st_pm_wait, busy};
            `OFF_ZPTR:   return {8'h0, zext_r, z_r};
            `OFF_SP:     return {16'h0, sp_r};
            `OFF_FLAGS:  return {24'h0, flags_r};
            `OFF_CTRL:   return {31'h0, wait_en_r};
            default:     return 32'h0;
        endcase
    endfunction

    assign s_axi_awready = !aw_got_r;
    assign s_axi_wready  = !w_got_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
    assign sw_wr   = wr_fire && addr_ok(awaddr_r);
    assign busy    = state_r != st_idle;

    always_comb begin
        wr_old = reg_view(awaddr_r);
        rd_val = reg_view(s_axi_araddr);
        for (int i = 0; i < 4; i++) begin
            wr_data[8*i +: 8] = wstrb_r[i] ? wdata_r[8*i +: 8] : wr_old[8*i +: 8];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r  <= 32'h0;
            wstrb_r  <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r  <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_got_r) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got_r <= 1'b0;
            end
            if (s_axi_wvalid && !w_got_r) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_got_r <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r  <= addr_ok(awaddr_r) ? `RESP_OKAY : `RESP_DECERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0;
            rresp_r  <= `RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r  <= addr_ok(s_axi_araddr) ? rd_val : 32'h0;
            rresp_r  <= addr_ok(s_axi_araddr) ? `RESP_OKAY : `RESP_DECERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Commands written while busy are dropped; software polls the busy bit
    assign accept  = sw_wr && awaddr_r == `OFF_CMD && !busy;
    assign cmd_op  = op_e'(wr_data[`CMD_OP_LSB +: 5]);
    assign cmd_rd  = wr_data[`CMD_REG_LSB +: 5];
    assign cmd_bit = wr_data[`CMD_BIT_LSB +: 3];
    assign mem_addr_n = (cmd_op == op_pop)  ? sp_r + 16'h1 :
                        (cmd_op == op_push) ? sp_r : z_r;
    assign needs_wait = wait_en_r && is_mem_rd(cmd_op) &&
                        mem_addr_n >= `SRAM_LO && mem_addr_n <= `SRAM_HI;
    // Reads stall while the memory is not ready, covering slow external RAM
    assign exec_go = state_r == st_exec && (!is_mem_rd(op_r) || dm_ready);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            st_idle: begin
                if (accept) begin
                    if (cmd_op == op_pm_store || cmd_op == op_pm_store_inc) begin
                        state_nxt = st_pm_wait;
                    end else if (needs_wait) begin
                        state_nxt = st_wait;
                    end else begin
                        state_nxt = st_exec;
                    end
                end
            end
            st_wait:    state_nxt = st_exec;
            st_exec: begin
                if (exec_go) begin
                    state_nxt = is_mem_rd(op_r) ? st_wb : st_idle;
                end
            end
            st_pm_wait: begin
                if (pm_done) begin
                    state_nxt = st_idle;
                end
            end
            st_wb:      state_nxt = st_idle;
            default:    state_nxt = st_idle;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r    <= st_idle;
            cmd_r      <= 32'h0;
            op_r       <= op_nop;
            rd_r       <= 5'h00;
            bit_r      <= 3'h0;
            wait_en_r  <= 1'b0;
            cyc_r      <= 8'h00;
            last_cyc_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            if (accept) begin
                cmd_r <= wr_data;
                op_r  <= cmd_op;
                rd_r  <= cmd_rd;
                bit_r <= cmd_bit;
            end
            if (sw_wr && awaddr_r == `OFF_CTRL) begin
                wait_en_r <= wr_data[0];
            end
            if (busy && state_nxt == st_idle) begin
                last_cyc_r <= cyc_r + 8'h01;
                cyc_r      <= 8'h00;
            end else if (busy && cyc_r != 8'hFF) begin
                cyc_r <= cyc_r + 8'h01;
            end
        end
    end

    shift_unit u_shift (
        .op   (op_r),
        .din  (regs[rd_r]),
        .fin  (flags_r),
        .dout (sh_dout),
        .fout (sh_fout)
    );

    rmw_unit u_rmw (
        .op      (op_r),
        .reg_val (regs[rd_r]),
        .ram_val (dm_rdata),
        .wr_val  (rmw_val)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 32; i++) begin
                regs[i] <= 8'h00;
            end
        end else if (exec_go && op_r == op_port_read) begin
            regs[rd_r] <= io_rdata;
        end else if (exec_go && is_shift(op_r)) begin
            regs[rd_r] <= sh_dout;
        end else if (exec_go && op_r == op_copy_t_flag_to_bit) begin
            regs[rd_r][bit_r] <= flags_r[`FLG_T];
        end else if (state_r == st_wb) begin
            regs[rd_r] <= tmp_r;
        end else if (sw_wr && awaddr_r[7]) begin
            regs[awaddr_r[6:2]] <= wr_data[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_r <= `FLAGS_RST;
        end else if (exec_go && is_shift(op_r)) begin
            flags_r <= sh_fout;
        end else if (exec_go && op_r == op_copy_bit_to_t_flag) begin
            flags_r[`FLG_T] <= regs[rd_r][bit_r];
        end else if (exec_go && op_r == op_flag_on) begin
            flags_r[bit_r] <= 1'b1;
        end else if (exec_go && op_r == op_flag_off) begin
            flags_r[bit_r] <= 1'b0;
        end else if (sw_wr && awaddr_r == `OFF_FLAGS) begin
            flags_r <= wr_data[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp_r <= `SP_RST;
        end else if (exec_go && op_r == op_push) begin
            sp_r <= sp_r - 16'h1;
        end else if (exec_go && op_r == op_pop) begin
            sp_r <= sp_r + 16'h1;
        end else if (sw_wr && awaddr_r == `OFF_SP) begin
            sp_r <= wr_data[15:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            z_r    <= 16'h0;
            zext_r <= 8'h00;
        end else if (state_r == st_pm_wait && pm_done && op_r == op_pm_store_inc) begin
            z_r <= z_r + `PM_STEP;
        end else if (sw_wr && awaddr_r == `OFF_ZPTR) begin
            z_r    <= wr_data[15:0];
            zext_r <= wr_data[23:16];
        end
    end

    // Program store request stands until the write logic reports completion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pm_req   <= 1'b0;
            pm_addr  <= 24'h0;
            pm_wdata <= 16'h0;
        end else if (accept && (cmd_op == op_pm_store || cmd_op == op_pm_store_inc)) begin
            pm_req   <= 1'b1;
            pm_addr  <= {zext_r, z_r};
            pm_wdata <= {regs[1], regs[0]};
        end else if (state_r == st_pm_wait && pm_done) begin
            pm_req <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dm_req   <= 1'b0;
            dm_we    <= 1'b0;
            dm_addr  <= 16'h0;
            dm_wdata <= 8'h00;
            tmp_r    <= 8'h00;
        end else if (accept) begin
            dm_req   <= is_mem_rd(cmd_op) || cmd_op == op_push;
            dm_we    <= cmd_op == op_push;
            dm_addr  <= mem_addr_n;
            dm_wdata <= regs[cmd_rd];
        end else if (exec_go) begin
            // Write-back at the same address keeps the exchange atomic
            dm_req   <= is_atomic(op_r);
            dm_we    <= is_atomic(op_r);
            dm_wdata <= rmw_val;
            tmp_r    <= dm_rdata;
        end else if (state_r == st_wb) begin
            dm_req <= 1'b0;
            dm_we  <= 1'b0;
        end
    end

    // Masked write lets bit set and clear finish without a read cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            io_re    <= 1'b0;
            io_we    <= 1'b0;
            io_addr  <= 6'h00;
            io_wdata <= 8'h00;
            io_wmask <= 8'h00;
        end else if (accept) begin
            io_addr  <= wr_data[`CMD_IO_LSB +: 6];
            io_re    <= cmd_op == op_port_read;
            io_we    <= cmd_op inside {op_port_write, op_set_io_bit, op_clear_io_bit};
            io_wdata <= (cmd_op == op_port_write) ? regs[cmd_rd] :
                        (cmd_op == op_set_io_bit) ? 8'hFF : 8'h00;
            io_wmask <= (cmd_op == op_port_write) ? 8'hFF : 8'h01 << cmd_bit;
        end else if (exec_go) begin
            io_re <= 1'b0;
            io_we <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_pm_stall: assert property (
        pm_req && !pm_done |=> pm_req && busy) else $error("store released early");
    a_pm_zstep: assert property (
        state_r == st_pm_wait && pm_done && op_r == op_pm_store_inc
        |=> z_r == $past(z_r) + 16'h2 && !busy) else $error("Z not advanced by 2");
    a_port_read: assert property (
        accept && cmd_op == op_port_read |=> io_re && busy ##1 !busy && !io_re)
        else $error("port read not one cycle");
    a_push_len: assert property (
        accept && cmd_op == op_push |=> dm_we ##1 !busy && sp_r == $past(sp_r) - 16'h1)
        else $error("push wrong");
    a_pop_len: assert property (
        accept && cmd_op == op_pop && !needs_wait ##1 dm_ready |=> busy ##1 !busy)
        else $error("pop not two cycles");
    a_rmw_len: assert property (
        accept && is_atomic(cmd_op) && !needs_wait ##1 dm_ready |=> dm_we && busy ##1 !busy)
        else $error("atomic not two cycles");
    a_rmw_or: assert property (
        state_r == st_exec && dm_ready && op_r == op_load_or_into_ram
        |=> dm_wdata == ($past(dm_rdata) | $past(regs[rd_r]))) else $error("OR wrong");
    a_sram_extra: assert property (
        accept && needs_wait |=> state_r == st_wait ##1 state_r == st_exec)
        else $error("no extra SRAM cycle");
    a_ext_stall: assert property (
        state_r == st_exec && is_mem_rd(op_r) && !dm_ready |=> state_r == st_exec)
        else $error("read left before ready");
    a_t_store: assert property (
        exec_go && op_r == op_copy_bit_to_t_flag
        |=> flags_r[`FLG_T] == $past(regs[rd_r][bit_r])) else $error("T not stored");
    a_io_bitset: assert property (
        accept && cmd_op == op_set_io_bit
        |=> io_we && io_wdata == 8'hFF && io_wmask == (8'h01 << $past(cmd_bit)))
        else $error("I/O bit set wrong");
    a_flags_kept: assert property (
        busy && !is_shift(op_r) && !(op_r inside {op_copy_bit_to_t_flag, op_flag_on,
        op_flag_off}) && !(sw_wr && awaddr_r == `OFF_FLAGS) |=> $stable(flags_r))
        else $error("flags changed");

    c_pm_store: cover property (state_r == st_pm_wait && pm_done);
    c_rmw_wait: cover property (state_r == st_wait ##1 exec_go && is_atomic(op_r));
    c_pop_done: cover property (state_r == st_wb && op_r == op_pop);
endmodule // cpu_instruction_subset_exec

//--- verif/mem_model.sv
/* Far side model: data SRAM, I/O space, program store handshake.
   Assumes the execution block's port timing on one clock. */
`timescale 1ns/1ns
module mem_model (
    input  wire logic        aclk,
    input  wire logic        dm_req,
    input  wire logic        dm_we,
    input  wire logic [15:0] dm_addr,
    input  wire logic [7:0]  dm_wdata,
    output logic      [7:0]  dm_rdata,
    output logic             dm_ready,
    input  wire logic        io_re,
    input  wire logic        io_we,
    input  wire logic [5:0]  io_addr,
    input  wire logic [7:0]  io_wdata,
    input  wire logic [7:0]  io_wmask,
    output logic      [7:0]  io_rdata,
    input  wire logic        pm_req,
    output logic             pm_done
);
    logic [7:0] mem [256];
    logic [7:0] io [64];
    logic [1:0] pc_r = 2'h0;
    logic       seen_r = 1'b0;
    // Reads outside SRAM wait one cycle
    assign dm_ready = !(dm_req && !dm_we && dm_addr[15:12] != 4'h2) || seen_r;
    // Inverted when unselected, so a stale sample shows
    assign dm_rdata = (dm_req && !dm_we) ? mem[dm_addr[7:0]] : ~mem[dm_addr[7:0]];
    assign io_rdata = io_re ? io[io_addr] : ~io[io_addr];
    assign pm_done  = pc_r == 2'h3;
    always @(posedge aclk) begin
        if (dm_req && dm_we) mem[dm_addr[7:0]] <= dm_wdata;
        if (io_we) io[io_addr] <= (io[io_addr] & ~io_wmask) | (io_wdata & io_wmask);
        pc_r <= pm_req ? pc_r + 2'h1 : 2'h0;
        seen_r <= dm_req && !dm_we && !dm_ready;
    end
endmodule // mem_model

//--- verif/tb_top.sv
/* Self-checking bench of the execution block over AXI4-Lite.
   Assumes mem_model as far side and the design files compiled first. */
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
    $display("Error at %0t got %h expected %h", $time, (a), (e)); end end
module tb_top;
    logic        aclk = 1'b0, aresetn = 1'b0, pm_req, pm_done, dm_req, dm_we, dm_ready;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, io_re, io_we, c;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, dm_wdata, dm_rdata, v, m;
    logic [7:0]  io_wdata, io_wmask, io_rdata;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic [23:0] pm_addr, pa;
    logic [15:0] pm_wdata, dm_addr, pd;
    logic [8:0]  e;
    logic [5:0]  io_addr;
    int          bad_count = 0, checks_done = 0, op, r;
    always #2 aclk = ~aclk;
    always @(posedge aclk) if (pm_req) {pa, pd} <= {pm_addr, pm_wdata};
    cpu_instruction_subset_exec u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pm_req,
        .pm_addr, .pm_wdata, .pm_done, .dm_req, .dm_we, .dm_addr, .dm_wdata, .dm_rdata,
        .dm_ready, .io_re, .io_we, .io_addr, .io_wdata, .io_wmask, .io_rdata);
    mem_model u_mem (.aclk, .dm_req, .dm_we, .dm_addr, .dm_wdata, .dm_rdata, .dm_ready,
        .io_re, .io_we, .io_addr, .io_wdata, .io_wmask, .io_rdata, .pm_req, .pm_done);
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta = 0, tw = 0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        // Ready sampled mid-cycle, release after the edge that took it
        while (!(ta && tw)) begin
            @(negedge aclk);
            {ta, tw} = {ta | s_axi_awready, tw | s_axi_wready};
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        do @(negedge aclk); while (!s_axi_bvalid);
        `CHK(s_axi_bresp, 2'h0)
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        {rv, rr} = {s_axi_rdata, s_axi_rresp};
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic run(input int cmd);
        int n = 0;
        wr(8'h00, cmd);
        // Bounded poll of the busy bit
        do begin
            rd(8'h04);
            n++;
        end while (rv[0] !== 1'b0 && n < 40);
        `CHK(rv[0], 1'b0)
    endtask
    function automatic logic [8:0] shx(input int o, input logic [7:0] x, input logic ci);
        case (o)
            11: return {x[7], x[6:0], 1'b0};
            12: return {x[0], 1'b0, x[7:1]};
            13: return {x[7], x[6:0], ci};
            14: return {x[0], ci, x[7:1]};
            default: return {x[0], x[7], x[7:1]};
        endcase
    endfunction
    task automatic final_report();
        $display("Checks %0d, errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        final_report();
    end
    initial begin
        void'($urandom(98));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 25; k++) begin
            op = 11 + k % 5;
            r = $urandom_range(31);
            c = $urandom;
            // Zero and all-ones first, for the zero flag
            v = k < 5 ? {8{k[0]}} : 8'($urandom);
            wr(8'h10, {31'h0, c});
            wr(8'(8'h80 + 4 * r), v);
            run(op | r << 5);
            e = shx(op, v, c);
            rd(8'(8'h80 + 4 * r));
            `CHK(rv[7:0], e[7:0])
            rd(8'h10);
            m = {2'h0, op < 14 && op[0] && v[3], e[8], ^e[8:7], e[7], ~|e[7:0], e[8]};
            `CHK(rv[7:0], m)
        end
        for (op = 7; op <= 10; op++) begin
            wr(8'h14, op % 2);
            wr(8'h08, op == 8 ? 32'h0010 : 32'h2010);
            {v, m} = $urandom;
            u_mem.mem[8'h10] = m;
            wr(8'h84, v);
            run(op | 1 << 5);
            rd(8'h84);
            `CHK(rv[7:0], m)
            `CHK(u_mem.mem[8'h10], op == 7 ? v : op == 8 ? v | m : op == 9 ? m & ~v : v ^ m)
        end
        wr(8'h8C, v);
        run(5 | 3 << 5);
        run(6 | 4 << 5);
        rd(8'h90);
        `CHK(rv[7:0], v)
        for (int b = 0; b < 8; b++) begin
            wr(8'h10, 0);
            run(20 | b << 10);
            rd(8'h10);
            `CHK(rv[7:0], 8'h01 << b)
            wr(8'h10, 32'hFF);
            run(21 | b << 10);
            rd(8'h10);
            `CHK(rv[7:0], ~(8'h01 << b))
        end
        wr(8'h94, m);
        run(4 | 5 << 5 | 42 << 13);
        `CHK(u_mem.io[42], m)
        run(18 | 3 << 10 | 42 << 13);
        run(19 | 7 << 10 | 42 << 13);
        `CHK(u_mem.io[42], (m | 8'h08) & 8'h7F)
        run(3 | 6 << 5 | 42 << 13);
        rd(8'h98);
        `CHK(rv[7:0], (m | 8'h08) & 8'h7F)
        wr(8'h9C, v);
        wr(8'hA0, 0);
        run(16 | 7 << 5 | 2 << 10);
        run(17 | 8 << 5 | 5 << 10);
        rd(8'hA0);
        `CHK(rv[7:0], {2'h0, v[2], 5'h0})
        wr(8'h80, v);
        wr(8'h84, m);
        wr(8'h08, 32'h050100);
        run(2);
        `CHK({pa, pd}, {24'h050100, m, v})
        rd(8'h08);
        `CHK(rv[23:0], 24'h050102)
        rd(8'h40);
        `CHK(rr, 2'h3)
        final_report();
    end
endmodule // tb_top
